// ### hdl/bit_op_regs.svh
`ifndef BIT_OP_REGS_SVH
`define BIT_OP_REGS_SVH
`define OPC_BIT_CLEAR 4'h4
`define OPC_BIT_SET 4'h5
`define OPC_TEST_ZERO 4'h6
`define OPC_TEST_ONE 4'h7
`define OPC_CLEAR_PREFIX 7'h03
`define NO_OPERATION_WORD 14'h0000
`define OPC_HI_POS 13
`define OPC_LO_POS 10
`define BIT_HI_POS 9
`define BIT_LO_POS 7
`define ADDR_HI_POS 6
`define CLEAR_HI_POS 13
`define CLEAR_LO_POS 7
`define RESET_WORD 14'h0000
`define RESET_ADDR 7'h00
`define RESET_DATA 8'h00
`endif

// ### hdl/bit_op_pkg.sv
package bit_op_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_BIT_CLEAR = 3'b001,
    OP_BIT_SET = 3'b010,
    OP_TEST_ZERO = 3'b011,
    OP_TEST_ONE = 3'b100,
    OP_CLEAR_REG = 3'b101
  } op_kind_t;

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_FLUSH = 1'b1
  } exec_state_t;

  typedef struct packed {
    logic wr_en;
    logic [6:0] addr;
    logic [7:0] data;
  } file_write_t;

  typedef struct packed {
    logic zero_set;
    logic skip;
    logic flush;
  } exec_status_t;
endpackage

// ### hdl/bit_op_clear_file_exec.sv
`timescale 1ns/1ns
`include "bit_op_regs.svh"

module bit_op_clear_file_exec (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic instr_valid_in,
  input wire logic [13:0] instr_in,
  input wire logic [7:0] file_rd_data_in,
  output logic [6:0] file_rd_addr_out,
  output logic file_wr_en_out,
  output logic [6:0] file_wr_addr_out,
  output logic [7:0] file_wr_data_out,
  output logic zero_set_out,
  output logic skip_out,
  output logic flush_out,
  output logic [13:0] exec_word_out,
  output logic busy_out
);

  bit_op_pkg::op_kind_t op_kind;
  bit_op_pkg::exec_state_t state_r;
  bit_op_pkg::exec_state_t state_nxt;
  bit_op_pkg::file_write_t wr_r;
  bit_op_pkg::file_write_t wr_nxt;
  bit_op_pkg::exec_status_t status_r;
  bit_op_pkg::exec_status_t status_nxt;
  logic [13:0] word_r;
  logic [2:0] bit_idx;
  logic [6:0] file_addr;
  logic sel_bit;
  logic take_skip;
  logic word_taken;

  function automatic bit_op_pkg::op_kind_t decode_op(input logic [13:0] w);
    bit_op_pkg::op_kind_t k;
    k = bit_op_pkg::OP_NONE;
    case (w[`OPC_HI_POS:`OPC_LO_POS])
      `OPC_BIT_CLEAR: k = bit_op_pkg::OP_BIT_CLEAR;
      `OPC_BIT_SET: k = bit_op_pkg::OP_BIT_SET;
      `OPC_TEST_ZERO: k = bit_op_pkg::OP_TEST_ZERO;
      `OPC_TEST_ONE: k = bit_op_pkg::OP_TEST_ONE;
      default: begin
        if (w[`CLEAR_HI_POS:`CLEAR_LO_POS] == `OPC_CLEAR_PREFIX) begin
          k = bit_op_pkg::OP_CLEAR_REG;
        end
      end
    endcase
    return k;
  endfunction

  // One-hot mask of the bit index
  function automatic logic [7:0] bit_mask_of(input logic [2:0] idx);
    logic [7:0] mask;
    mask = 8'h01 << idx;
    return mask;
  endfunction

  // Rewrite one bit, keep the rest
  function automatic logic [7:0] write_bit(
    input logic [7:0] data,
    input logic [2:0] idx,
    input logic value
  );
    logic [7:0] res;
    if (value) begin
      res = data | bit_mask_of(idx);
    end else begin
      res = data & ~bit_mask_of(idx);
    end
    return res;
  endfunction

  function automatic logic read_bit(input logic [7:0] data, input logic [2:0] idx);
    logic b;
    b = data[idx];
    return b;
  endfunction

  function automatic logic skip_taken(input bit_op_pkg::op_kind_t k, input logic b);
    logic s;
    case (k)
      bit_op_pkg::OP_TEST_ZERO: s = ~b;
      bit_op_pkg::OP_TEST_ONE: s = b;
      default: s = 1'b0;
    endcase
    return s;
  endfunction

  assign bit_idx = instr_in[`BIT_HI_POS:`BIT_LO_POS];
  assign file_addr = instr_in[`ADDR_HI_POS:0];
  assign sel_bit = read_bit(file_rd_data_in, bit_idx);
  assign file_rd_addr_out = file_addr;

  assign word_taken = instr_valid_in && (state_r == bit_op_pkg::ST_RUN);

  always_comb begin
    op_kind = bit_op_pkg::OP_NONE;
    if (word_taken) begin
      op_kind = decode_op(instr_in);
    end
  end

  always_comb begin
    take_skip = skip_taken(op_kind, sel_bit);
  end

  always_comb begin
    wr_nxt = '{wr_en: 1'b0, addr: file_addr, data: file_rd_data_in};
    status_nxt = '{zero_set: 1'b0, skip: take_skip, flush: 1'b0};
    case (op_kind)
      bit_op_pkg::OP_BIT_CLEAR: begin
        wr_nxt.wr_en = 1'b1;
        wr_nxt.data = write_bit(file_rd_data_in, bit_idx, 1'b0);
      end
      bit_op_pkg::OP_BIT_SET: begin
        wr_nxt.wr_en = 1'b1;
        wr_nxt.data = write_bit(file_rd_data_in, bit_idx, 1'b1);
      end
      bit_op_pkg::OP_CLEAR_REG: begin
        wr_nxt.wr_en = 1'b1;
        wr_nxt.data = `RESET_DATA;
        status_nxt.zero_set = 1'b1;
      end
      default: begin
        wr_nxt.wr_en = 1'b0;
      end
    endcase
    if (state_r == bit_op_pkg::ST_FLUSH) begin
      status_nxt.flush = 1'b1;
    end
  end

  always_comb begin
    state_nxt = bit_op_pkg::ST_RUN;
    case (state_r)
      bit_op_pkg::ST_RUN: begin
        if (take_skip) begin
          state_nxt = bit_op_pkg::ST_FLUSH;
        end else begin
          state_nxt = bit_op_pkg::ST_RUN;
        end
      end
      bit_op_pkg::ST_FLUSH: begin
        state_nxt = bit_op_pkg::ST_RUN;
      end
      default: begin
        state_nxt = bit_op_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= bit_op_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_r.wr_en <= 1'b0;
      wr_r.addr <= `RESET_ADDR;
      wr_r.data <= `RESET_DATA;
    end else begin
      wr_r <= wr_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_r.zero_set <= 1'b0;
      status_r.skip <= 1'b0;
      status_r.flush <= 1'b0;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_r <= `RESET_WORD;
    end else if (state_r == bit_op_pkg::ST_FLUSH) begin
      word_r <= `NO_OPERATION_WORD;
    end else if (instr_valid_in) begin
      word_r <= instr_in;
    end else begin
      word_r <= `NO_OPERATION_WORD;
    end
  end

  assign file_wr_en_out = wr_r.wr_en;
  assign file_wr_addr_out = wr_r.addr;
  assign file_wr_data_out = wr_r.data;
  assign zero_set_out = status_r.zero_set;
  assign skip_out = status_r.skip;
  assign flush_out = status_r.flush;
  assign exec_word_out = word_r;
  assign busy_out = (state_r == bit_op_pkg::ST_FLUSH);

endmodule

// ### tb/bit_op_chk.sv
`timescale 1ns/1ns
module bit_op_chk (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic instr_valid_in,
  input wire logic [13:0] instr_in,
  input wire logic [7:0] file_rd_data_in,
  input wire logic file_wr_en_out,
  input wire logic [7:0] file_wr_data_out,
  input wire logic zero_set_out,
  input wire logic skip_out,
  input wire logic flush_out,
  input wire logic busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire t = instr_valid_in && !busy_out;
  wire [3:0] o = instr_in[13:10];
  wire [7:0] d = file_rd_data_in;
  wire [7:0] m = 8'h01 << instr_in[9:7];
  wire [7:0] dc = d & ~m;
  wire [7:0] ds = d | m;
  wire [7:0] q = file_wr_data_out;
  wire c = t && instr_in[13:7] == 7'h03;
  wire h = t && o[3:1] == 3'h3 && ((d & m) != 0) == o[0];
  wire n = t && o[3:1] == 3'h3 && !h;
  property p_bc; t && o == 4'h4 |=> file_wr_en_out && q == $past(dc); endproperty
  a_bc: assert property (p_bc) else $error("bit clear");
  property p_bs; t && o == 4'h5 |=> file_wr_en_out && q == $past(ds); endproperty
  a_bs: assert property (p_bs) else $error("bit set");
  property p_tk; h |=> skip_out && busy_out ##1 flush_out && !busy_out; endproperty
  a_tk: assert property (p_tk) else $error("skip");
  property p_nt; n |=> !skip_out && !busy_out && !file_wr_en_out; endproperty
  a_nt: assert property (p_nt) else $error("no skip");
  property p_cr; c |=> file_wr_en_out && zero_set_out && q == 8'h00; endproperty
  a_cr: assert property (p_cr) else $error("clear");
  property p_rf; busy_out |=> !file_wr_en_out && !skip_out; endproperty
  a_rf: assert property (p_rf) else $error("refuse");
  property p_zs; zero_set_out |-> $past(c); endproperty
  a_zs: assert property (p_zs) else $error("zero flag");
  property p_bz; busy_out |-> $past(h); endproperty
  a_bz: assert property (p_bz) else $error("busy");
  cover property (skip_out);
  cover property (zero_set_out);
  cover property (busy_out && instr_valid_in);
endmodule
bind bit_op_clear_file_exec bit_op_chk chk (
  .clk_in(clk_in),
  .rst_b_in(rst_b_in),
  .instr_valid_in(instr_valid_in),
  .instr_in(instr_in),
  .file_rd_data_in(file_rd_data_in),
  .file_wr_en_out(file_wr_en_out),
  .file_wr_data_out(file_wr_data_out),
  .zero_set_out(zero_set_out),
  .skip_out(skip_out),
  .flush_out(flush_out),
  .busy_out(busy_out)
);

// ### tb/file_model.sv
`timescale 1ns/1ns
module file_model (
  input wire logic clk_in,
  input wire bit_op_pkg::file_write_t wr_in,
  input wire logic [6:0] rd_addr_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] m [128];
  initial for (int i = 0; i < 128; i++) m[i] = 8'(i) ^ 8'h5a;
  assign rd_data_out = m[rd_addr_in];
  always @(posedge clk_in) if (wr_in.wr_en) m[wr_in.addr] <= wr_in.data;
endmodule

// ### tb/bit_op_clear_file_exec_tb.sv
`timescale 1ns/1ns
module bit_op_clear_file_exec_tb;
  logic clk_in = 0, rst_b_in = 0, instr_valid_in = 0;
  logic [13:0] instr_in = 14'h0000, exec_word_out;
  logic [7:0] file_rd_data_in, file_wr_data_out;
  logic [6:0] file_rd_addr_out, file_wr_addr_out;
  logic file_wr_en_out, zero_set_out, skip_out, flush_out, busy_out;
  int errors = 0, check_count = 0;
  bit_op_pkg::file_write_t wr;
  assign wr = {file_wr_en_out, file_wr_addr_out, file_wr_data_out};
  always #50 clk_in = ~clk_in;
  bit_op_clear_file_exec dut (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .instr_valid_in(instr_valid_in),
    .instr_in(instr_in),
    .file_rd_data_in(file_rd_data_in),
    .file_rd_addr_out(file_rd_addr_out),
    .file_wr_en_out(file_wr_en_out),
    .file_wr_addr_out(file_wr_addr_out),
    .file_wr_data_out(file_wr_data_out),
    .zero_set_out(zero_set_out),
    .skip_out(skip_out),
    .flush_out(flush_out),
    .exec_word_out(exec_word_out),
    .busy_out(busy_out)
  );
  file_model fm (.clk_in(clk_in), .wr_in(wr), .rd_addr_in(file_rd_addr_out),
    .rd_data_out(file_rd_data_in));
  function automatic logic [7:0] iv(int a);
    return 8'(a) ^ 8'h5a;
  endfunction
  task chk(logic [15:0] g, x);
    check_count++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task put(logic [13:0] w);
    instr_in = w;
    instr_valid_in = 1;
    @(posedge clk_in);
    #1;
  endtask
  task t_bits;
    for (int b = 0; b < 8; b++) begin
      put({4'h4, 3'(b), 7'(127 - b)});
      put({4'h5, 3'(b), 7'(b)});
    end
    put(14'h0000);
    for (int b = 0; b < 8; b++) begin
      chk(fm.m[127 - b], iv(127 - b) & ~(8'h01 << b));
      chk(fm.m[b], iv(b) | 8'h01 << b);
    end
    $display("t_bits done");
  endtask
  task t_skip;
    logic tk;
    for (int k = 0; k < 4; k++) begin
      tk = k[0] == k[1];
      put({4'h6 + 4'(k[1]), k[0] ? 3'h1 : 3'h2, 7'h09});
      chk(skip_out, tk);
      chk(busy_out, tk);
      put({7'h03, 7'(20 + k)});
      chk(zero_set_out, !tk);
      chk(flush_out, tk);
      chk(exec_word_out, tk ? 14'h0000 : {7'h03, 7'(20 + k)});
      put(14'h0000);
      chk(fm.m[20 + k], tk ? iv(20 + k) : 8'h00);
    end
    $display("t_skip done");
  endtask
  task t_reset;
    put({4'h6, 3'h2, 7'h09});
    chk(busy_out, 1'b1);
    rst_b_in = 0;
    #1;
    chk({skip_out, busy_out, exec_word_out}, 16'h0000);
    chk({flush_out, zero_set_out, file_wr_en_out}, 3'h0);
    @(posedge clk_in);
    #1;
    rst_b_in = 1;
    put({4'h5, 3'h7, 7'h30});
    chk({file_wr_en_out, flush_out, file_wr_data_out}, {2'b10, iv(48) | 8'h80});
    chk(file_wr_addr_out, 7'h30);
    $display("t_reset done");
  endtask
  task complete_run;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    #1;
    rst_b_in = 1;
    t_bits;
    t_skip;
    t_reset;
    complete_run;
  end
endmodule
